// >>> src/sma_top.sv
// Speed-mode auxiliary logic: reference filter, zero clamp, encoder divider, speed match
// Functional notes
// - Speed reference first-order lag, millisecond time constant
// - Clamp engages below threshold when requested
// - Clamped motor held within one count
// - Clamp threshold used only in clamp modes
// - Threshold capped at motor maximum speed
// - Clamp inputs are active low
// - Alternate clamp assigned enables clamp in speed
// - Differential A, B and index encoder outputs
// - Output phase ignores rotation direction setting
// - Divider yields configured pulses per revolution
// - Speed match when difference below band
// - Speed match output is active low
// - Shared pin: position done or speed match
// - Soft start shape selects reference profile
`timescale 1ns/1ps
module sma_top
    import sma_pkg::*;
#(
    parameter int MS_CYC  = MS_CYCLES,
    parameter int ENC_CPR = ENC_CPR_DEF,
    parameter int KP      = KP_DEF
) (
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic [ADDR_W-1:0]  avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [DATA_W-1:0]  avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [DATA_W-1:0]  avs_readdata,
    output logic                    avs_waitrequest,
    input  wire logic signed [15:0] speed_ref,
    input  wire logic signed [15:0] actual_speed,
    input  wire logic               clamp_request_input,
    input  wire logic               clamp_alt_input,
    input  wire logic               position_done_in,
    input  wire logic               enc_a_in,
    input  wire logic               enc_b_in,
    input  wire logic               enc_index_in,
    output logic signed [15:0]      speed_cmd,
    output logic                    clamp_active,
    output logic                    enc_out_a,
    output logic                    enc_out_a_n,
    output logic                    enc_out_b,
    output logic                    enc_out_b_n,
    output logic                    enc_out_index,
    output logic                    enc_out_index_n,
    output logic                    speed_match_out,
    output logic                    irq
);
    if (MS_CYC < 1 || ENC_CPR < 4 * 16384 || ENC_CPR > 1048576 || KP < 1 || KP > 16) begin : g_chk
        $error("sma_top: unsupported parameter value");
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    function automatic logic signed [31:0] lag_step(input logic signed [31:0] y,
                                                    input logic signed [15:0] x,
                                                    input logic [13:0]        t);
        logic signed [33:0] d;
        logic signed [33:0] den;
        logic signed [33:0] q;
        d   = $signed({{2{x[15]}}, x, 16'h0000}) - $signed({{2{y[31]}}, y});
        den = $signed({20'h00000, t}) + 34'sh1;
        q   = d / den;
        // Snap once the step truncates to zero, else the output parks one count short
        return (t == 14'h0000 || q == 34'sh0) ? $signed({x, 16'h0000}) : y + q[31:0];
    endfunction

    function automatic logic [16:0] abs17(input logic signed [16:0] v);
        return v[16] ? 17'(-v) : 17'(v);
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Software state
    logic [3:0]         control_mode_select;
    logic               rotation_direction_select;
    logic               input_terminal_assign_a;
    logic [1:0]         soft_start_shape;
    logic [13:0]        ref_filter_time;
    logic [13:0]        scurve_rise_time;
    logic [11:0]        clamp_speed_threshold;
    logic [14:0]        output_pulses_per_rev;
    logic [14:0]        ppr_active;
    logic [6:0]         speed_match_band;
    logic [11:0]        max_speed;
    logic [EV_N-1:0]    status;
    logic [EV_N-1:0]    mask;
    // Datapath state
    logic [31:0]        ms_cnt;
    logic               ms_tick;
    logic signed [31:0] stage1;
    logic signed [31:0] stage2;
    sma_clamp_t         st;
    logic signed [31:0] pos;
    logic signed [31:0] clamp_pos;
    logic [1:0]         enc_prev;
    logic [20:0]        div_acc;
    logic [1:0]         out_q;
    logic               index_prev;
    logic               match_prev;

    // Bus decode
    wire        bus_req   = avs_read | avs_write;
    wire        we        = avs_write & ~avs_waitrequest;
    wire [5:0]  wofs      = {avs_address[5:2], 2'b00};
    wire [31:0] ctrl_word = {23'h0, 1'b0, soft_start_shape, input_terminal_assign_a,
                             rotation_direction_select, control_mode_select};
    wire [31:0] wv        = be_merge(ctrl_word, avs_writedata, avs_byteenable);
    wire [31:0] wn        = be_merge(32'h0, avs_writedata, avs_byteenable);

    // Mode decode
    wire is_position = (control_mode_select == MODE_POSITION);
    wire is_speed    = (control_mode_select == MODE_SPEED) ||
                       (control_mode_select == MODE_ZERO_CLAMP);
    wire clamp_mode  = (control_mode_select == MODE_ZERO_CLAMP) ||
                       ((control_mode_select == MODE_SPEED) && input_terminal_assign_a);
    wire req_on      = ~clamp_request_input |
                       (input_terminal_assign_a & ~clamp_alt_input);
    wire [11:0] thr_eff = (clamp_speed_threshold > max_speed) ? max_speed
                                                               : clamp_speed_threshold;
    wire [16:0] ref_abs = abs17(17'(speed_ref));
    wire below_thr   = ref_abs < {5'h00, thr_eff};
    wire engage      = (st == ST_RUN) && clamp_mode && req_on && below_thr;
    wire release_now = (st == ST_CLAMP) && (!clamp_mode || !req_on || !below_thr);

    // Reference shaping: stage 2 rounds with the S-curve time or repeats the lag
    wire [13:0] t2 = (soft_start_shape == 2'h1) ? scurve_rise_time : ref_filter_time;
    wire signed [15:0] shaped = soft_start_shape[0] ? stage2[31:16] : stage1[31:16];

    sma_clamp_t next_st;

    // Position hold
    wire signed [31:0] pos_err = pos - clamp_pos;
    wire [31:0] err_abs = pos_err[31] ? 32'(-pos_err) : 32'(pos_err);
    wire signed [15:0] err_lim = (err_abs > 32'd1023) ? (pos_err[31] ? -16'sd1023 : 16'sd1023)
                                                      : pos_err[15:0];
    wire signed [15:0] hold_cmd = (err_abs <= 32'd1) ? 16'sh0000 : 16'(-(err_lim * KP));
    wire signed [15:0] run_cmd  = rotation_direction_select ? 16'(-shaped) : shaped;
    wire signed [15:0] next_cmd = (next_st == ST_CLAMP) ? hold_cmd : run_cmd;

    // Encoder decode and divide
    wire [1:0] enc_cur  = {enc_a_in, enc_a_in ^ enc_b_in};
    wire [1:0] enc_dlt  = enc_cur - enc_prev;
    wire       step_up  = (enc_dlt == 2'h1);
    wire       step_dn  = (enc_dlt == 2'h3);
    wire [20:0] inc     = {4'h0, ppr_active, 2'b00};
    wire [20:0] cpr     = 21'(ENC_CPR);
    wire [20:0] acc_up  = div_acc + inc;
    wire       out_up   = step_up && (acc_up >= cpr);
    wire       out_dn   = step_dn && (div_acc < inc);
    wire [20:0] next_acc = out_up ? acc_up - cpr :
                           step_up ? acc_up :
                           out_dn ? div_acc + cpr - inc :
                           step_dn ? div_acc - inc : div_acc;
    // Direction setting only flips the command, never the output phase
    wire [1:0] next_q   = out_up ? out_q + 2'h1 : out_dn ? out_q - 2'h1 : out_q;

    // Speed match
    wire [16:0] dv_abs  = abs17(17'(speed_ref) - 17'(actual_speed));
    wire match_now      = is_speed && (dv_abs < {10'h000, speed_match_band});

    // Events and interrupt
    wire [EV_N-1:0] ev  = {enc_index_in & ~index_prev, match_now & ~match_prev,
                           release_now, engage};
    wire [EV_N-1:0] clr = (we && wofs == OFS_STATUS) ? wn[EV_N-1:0] : '0;
    wire [EV_N-1:0] next_status = (status & ~clr) | ev;

    assign next_st = engage ? ST_CLAMP : release_now ? ST_RUN : st;

    wire [31:0] rd_mux =
        (wofs == OFS_CTRL)      ? ctrl_word :
        (wofs == OFS_FILT)      ? {18'h0, ref_filter_time} :
        (wofs == OFS_SCURVE)    ? {18'h0, scurve_rise_time} :
        (wofs == OFS_CLAMP_SPD) ? {20'h0, clamp_speed_threshold} :
        (wofs == OFS_PPR)       ? {17'h0, output_pulses_per_rev} :
        (wofs == OFS_BAND)      ? {25'h0, speed_match_band} :
        (wofs == OFS_MAX_SPD)   ? {20'h0, max_speed} :
        (wofs == OFS_STATUS)    ? {28'h0, status} :
        (wofs == OFS_MASK)      ? {28'h0, mask} :
        (wofs == OFS_STATE)     ? {shaped, 14'h0, match_now, clamp_active} :
        (wofs == OFS_POS_ERR)   ? pos_err : 32'h0;

    // Register writes, values outside their range saturate, except max_speed, which takes the low 12 bits as written
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            control_mode_select       <= RST_MODE;
            rotation_direction_select <= 1'b0;
            input_terminal_assign_a   <= 1'b0;
            soft_start_shape          <= RST_SHAPE;
            ref_filter_time           <= RST_FILT;
            scurve_rise_time          <= RST_SCURVE;
            clamp_speed_threshold     <= RST_CLAMP_SPD;
            output_pulses_per_rev     <= RST_PPR;
            speed_match_band          <= RST_BAND;
            max_speed                 <= RST_MAX_SPD;
            mask                      <= '0;
        end else if (we) begin
            if (wofs == OFS_CTRL) begin
                control_mode_select       <= wv[CTRL_MODE_LSB +: 4];
                rotation_direction_select <= wv[CTRL_DIR_BIT];
                input_terminal_assign_a   <= wv[CTRL_ALT_BIT];
                soft_start_shape          <= wv[CTRL_SHAPE_LSB +: 2];
            end
            if (wofs == OFS_FILT) begin
                ref_filter_time <= (wn[15:0] > 16'(MAX_TIME_MS)) ? MAX_TIME_MS : wn[13:0];
            end
            if (wofs == OFS_SCURVE) begin
                scurve_rise_time <= (wn[15:0] > 16'(MAX_TIME_MS)) ? MAX_TIME_MS : wn[13:0];
            end
            if (wofs == OFS_CLAMP_SPD) begin
                clamp_speed_threshold <= (wn[15:0] > 16'(MAX_CLAMP_SPD)) ? MAX_CLAMP_SPD
                                                                         : wn[11:0];
            end
            if (wofs == OFS_PPR) begin
                output_pulses_per_rev <= (wn[15:0] > 16'(RST_PPR)) ? RST_PPR :
                                         (wn[15:0] < 16'(MIN_PPR)) ? MIN_PPR : wn[14:0];
            end
            if (wofs == OFS_BAND) begin
                speed_match_band <= (wn[7:0] > 8'(MAX_BAND)) ? MAX_BAND : wn[6:0];
            end
            if (wofs == OFS_MAX_SPD) begin
                max_speed <= wn[11:0];
            end
            if (wofs == OFS_MASK) begin
                mask <= wn[EV_N-1:0];
            end
        end
    end

    // Bus answer one cycle after the request is seen
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // Divider setting only changes on a restart, taking effect at once at any point in the revolution
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ppr_active <= RST_PPR;
        end else if (we && wofs == OFS_CTRL && avs_byteenable[1] &&
                     avs_writedata[CTRL_RESTART_BIT]) begin
            ppr_active <= output_pulses_per_rev;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ms_cnt  <= 32'h0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == 32'(MS_CYC - 1));
            ms_cnt  <= (ms_cnt == 32'(MS_CYC - 1)) ? 32'h0 : ms_cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= 32'sh0;
            stage2 <= 32'sh0;
        end else if (ms_tick) begin
            stage1 <= lag_step(stage1, speed_ref, ref_filter_time);
            stage2 <= lag_step(stage2, stage1[31:16], t2);
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st           <= ST_RUN;
            clamp_pos    <= 32'sh0;
            clamp_active <= 1'b0;
            speed_cmd    <= 16'sh0000;
        end else begin
            st           <= next_st;
            clamp_active <= (next_st == ST_CLAMP);
            speed_cmd    <= next_cmd;
            if (engage) begin
                clamp_pos <= pos;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enc_prev   <= 2'h0;
            pos        <= 32'sh0;
            div_acc    <= 21'h0;
            out_q      <= 2'h0;
            index_prev <= 1'b0;
        end else begin
            enc_prev   <= enc_cur;
            pos        <= step_up ? pos + 32'sh1 : step_dn ? pos - 32'sh1 : pos;
            div_acc    <= next_acc;
            out_q      <= next_q;
            index_prev <= enc_index_in;
        end
    end

    // Complementary pairs come from their own flops
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            enc_out_a       <= 1'b0;
            enc_out_a_n     <= 1'b1;
            enc_out_b       <= 1'b0;
            enc_out_b_n     <= 1'b1;
            enc_out_index   <= 1'b0;
            enc_out_index_n <= 1'b1;
        end else begin
            enc_out_a       <= next_q[1];
            enc_out_a_n     <= ~next_q[1];
            enc_out_b       <= next_q[1] ^ next_q[0];
            enc_out_b_n     <= ~(next_q[1] ^ next_q[0]);
            enc_out_index   <= enc_index_in;
            enc_out_index_n <= ~enc_index_in;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            status          <= '0;
            match_prev      <= 1'b0;
            irq             <= 1'b0;
            speed_match_out <= 1'b1;
        end else begin
            status          <= next_status;
            match_prev      <= match_now;
            irq             <= |(next_status & mask);
            speed_match_out <= is_position ? ~position_done_in : ~match_now;
        end
    end

    filt_zero_a: assert property (ms_tick && ref_filter_time == 14'h0000 |=>
        stage1[31:16] == $past(speed_ref)) else $error("lag bypass failed");
    clamp_engage_a: assert property (engage |=> st == ST_CLAMP && clamp_active)
        else $error("clamp did not engage");
    clamp_hold_a: assert property (next_st == ST_CLAMP && err_abs <= 32'd1 |=>
        speed_cmd == 16'sh0000) else $error("hold command not zero");
    clamp_mode_a: assert property (!clamp_mode |=> st == ST_RUN)
        else $error("clamp outside clamp mode");
    thr_cap_a: assert property (clamp_speed_threshold > max_speed |->
        thr_eff == max_speed) else $error("threshold not capped");
    alt_enable_a: assert property (control_mode_select == MODE_SPEED &&
        input_terminal_assign_a |-> clamp_mode) else $error("alt assign ignored");
    diff_pair_a: assert property (enc_out_a != enc_out_a_n && enc_out_b != enc_out_b_n
        && enc_out_index != enc_out_index_n) else $error("pair not complementary");
    dir_phase_a: assert property ($changed(rotation_direction_select) && !step_up &&
        !step_dn |=> $stable(enc_out_a) && $stable(enc_out_b)) else $error("phase moved");
    div_range_a: assert property (div_acc < cpr ##1 (out_q - $past(out_q)) != 2'h2)
        else $error("divider out of range");
    match_pin_a: assert property (match_now && !is_position |=> !speed_match_out)
        else $error("match pin not low");
    pos_pin_a: assert property (is_position |=>
        speed_match_out == !$past(position_done_in)) else $error("pin not position done");
    release_a: assert property (st == ST_CLAMP && !req_on |=>
        st == ST_RUN && !clamp_active) else $error("clamp did not release");
    bus_answer_a: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule

// >>> inc/sma_pkg.sv
// Shared constants for the speed-mode auxiliary logic
package sma_pkg;
    localparam int          DATA_W           = 32;
    localparam int          ADDR_W           = 6;
    // Register byte offsets
    localparam logic [5:0]  OFS_CTRL         = 6'h00;
    localparam logic [5:0]  OFS_FILT         = 6'h04;
    localparam logic [5:0]  OFS_SCURVE       = 6'h08;
    localparam logic [5:0]  OFS_CLAMP_SPD    = 6'h0c;
    localparam logic [5:0]  OFS_PPR          = 6'h10;
    localparam logic [5:0]  OFS_BAND         = 6'h14;
    localparam logic [5:0]  OFS_MAX_SPD      = 6'h18;
    localparam logic [5:0]  OFS_STATUS       = 6'h1c;
    localparam logic [5:0]  OFS_MASK         = 6'h20;
    localparam logic [5:0]  OFS_STATE        = 6'h24;
    localparam logic [5:0]  OFS_POS_ERR      = 6'h28;
    // Control word fields
    localparam int          CTRL_MODE_LSB    = 0;
    localparam int          CTRL_DIR_BIT     = 4;
    localparam int          CTRL_ALT_BIT     = 5;
    localparam int          CTRL_SHAPE_LSB   = 6;
    localparam int          CTRL_RESTART_BIT = 8;
    // Control modes
    localparam logic [3:0]  MODE_SPEED       = 4'h0;
    localparam logic [3:0]  MODE_POSITION    = 4'h1;
    localparam logic [3:0]  MODE_ZERO_CLAMP  = 4'ha;
    // Reset values and limits
    localparam logic [3:0]  RST_MODE         = 4'h0;
    localparam logic [1:0]  RST_SHAPE        = 2'h0;
    localparam logic [13:0] RST_FILT         = 14'h0000;
    localparam logic [13:0] RST_SCURVE       = 14'h0000;
    localparam logic [13:0] MAX_TIME_MS      = 14'h2710;
    localparam logic [11:0] RST_CLAMP_SPD    = 12'h00a;
    localparam logic [11:0] MAX_CLAMP_SPD    = 12'hbb8;
    localparam logic [14:0] RST_PPR          = 15'h4000;
    localparam logic [14:0] MIN_PPR          = 15'h0010;
    localparam logic [6:0]  RST_BAND         = 7'h0a;
    localparam logic [6:0]  MAX_BAND         = 7'h64;
    localparam logic [11:0] RST_MAX_SPD      = 12'hbb8;
    // Event bits of status and mask
    localparam int          EV_ENGAGE        = 0;
    localparam int          EV_RELEASE       = 1;
    localparam int          EV_MATCH         = 2;
    localparam int          EV_INDEX         = 3;
    localparam int          EV_N             = 4;
    // Timing: filter steps once per millisecond
    localparam int          TICK_MS          = 1;
    localparam int          CLK_MHZ          = 125;
    localparam int          MS_CYCLES        = TICK_MS * CLK_MHZ * 1000;
    localparam int          FRAC             = 16;
    localparam int          ENC_CPR_DEF      = 65536;
    localparam int          KP_DEF           = 4;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_CLAMP = 2'b10
    } sma_clamp_t;
endpackage

// >>> bench/sma_host_model.sv
// Host controller model: counts divided pulses and index marks
`timescale 1ns/1ps
module sma_host_model (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic enc_a,
    input  wire logic enc_index,
    output int        a_edges,
    output logic      index_trusted
);
    logic a_d;
    logic idx_d;
    int   idx_seen;
    // Index is not a zero reference before two revolutions
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            a_d      <= 1'b0;
            idx_d    <= 1'b0;
            idx_seen <= 0;
            a_edges  <= 0;
        end else begin
            a_d   <= enc_a;
            idx_d <= enc_index;
            if (enc_a && !a_d) begin
                a_edges <= a_edges + 1;
            end
            if (enc_index && !idx_d) begin
                idx_seen <= idx_seen + 1;
            end
        end
    end
    assign index_trusted = (idx_seen >= 2);
endmodule

// >>> bench/speed_mode_aux_logic_test.sv
// Self-checking bench for the speed-mode auxiliary logic
`timescale 1ns/1ps
module speed_mode_aux_logic_test;
    import sma_pkg::*;
    logic mclk = 1'b0;
    logic rstn, rd, wr, cr_n, ca_n, pdone, ea, eb, ei, cl, oa, oan, ob, obn, oi, oin, sm, irq, wq;
    logic [5:0] adr;
    logic [31:0] wd, rdata, d;
    logic signed [15:0] sref, aspd, scmd;
    int n_errors = 0, n_tests = 0, cyc = 0, pos = 0, edges, k;
    logic trusted;
    sma_top #(.MS_CYC(8)) u_dut (.mclk(mclk), .rstn(rstn), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(wq), .speed_ref(sref), .actual_speed(aspd), .clamp_request_input(cr_n),
        .clamp_alt_input(ca_n), .position_done_in(pdone), .enc_a_in(ea), .enc_b_in(eb),
        .enc_index_in(ei), .speed_cmd(scmd), .clamp_active(cl), .enc_out_a(oa),
        .enc_out_a_n(oan), .enc_out_b(ob), .enc_out_b_n(obn), .enc_out_index(oi),
        .enc_out_index_n(oin), .speed_match_out(sm), .irq(irq));
    sma_host_model u_host (.mclk(mclk), .rstn(rstn), .enc_a(oa), .enc_index(oi),
        .a_edges(edges), .index_trusted(trusted));
    always #4 mclk = ~mclk;
    // Whole run needs about 1100 cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            final_report;
        end
    end
    task automatic final_report;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkb(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
        adr <= a;
        wd  <= v;
        wr  <= w;
        rd  <= !w;
        do @(posedge mclk); while (wq !== 1'b0);
        d  = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        // Idle edge so a following call never reassigns the strobes in this step
        @(posedge mclk);
    endtask
    task automatic settle;
        repeat (3) @(posedge mclk);
    endtask
    task automatic test_regs;
        bus(0, OFS_FILT, 0);      chk("filt", 32'h0, d);
        bus(0, OFS_CLAMP_SPD, 0); chk("clamp_spd", 32'ha, d);
        bus(0, OFS_PPR, 0);       chk("ppr", 32'h4000, d);
        bus(0, OFS_BAND, 0);      chk("band", 32'ha, d);
        bus(0, 6'h3c, 0);         chk("unmapped", 32'h0, d);
        $display("test regs done");
    endtask
    task automatic test_match;
        bus(1, OFS_CTRL, 32'h0);
        sref <= 16'sd2000; aspd <= 16'sd2009; repeat (20) @(posedge mclk);
        chk("cmd", 32'(16'sd2000), 32'(scmd));
        chkb("match", 1'b0, sm);
        aspd <= 16'sd2010; settle; chkb("match", 1'b1, sm);
        bus(1, OFS_BAND, 32'h64);
        aspd <= 16'sd1901; settle; chkb("match", 1'b0, sm);
        aspd <= 16'sd1900; settle; chkb("match", 1'b1, sm);
        bus(1, OFS_CTRL, 32'h1);
        pdone <= 1'b1; settle; chkb("pin", 1'b0, sm);
        pdone <= 1'b0; settle; chkb("pin", 1'b1, sm);
        $display("test match done");
    endtask
    task automatic test_clamp;
        bus(1, OFS_CTRL, 32'h0); bus(1, OFS_MASK, 32'h1);
        sref <= 16'sd5; cr_n <= 1'b0; settle; chkb("clamp", 1'b0, cl);
        bus(1, OFS_CTRL, 32'ha); settle; chkb("clamp", 1'b1, cl);
        chkb("irq", 1'b1, irq); chk("hold", 32'h0, 32'(scmd));
        bus(0, OFS_STATUS, 0); chk("status", 32'h1, d & 32'h1);
        bus(1, OFS_STATUS, 32'h1); settle; chkb("irq", 1'b0, irq);
        cr_n <= 1'b1; settle; chkb("clamp", 1'b0, cl);
        cr_n <= 1'b0; sref <= 16'sd10; settle; chkb("clamp", 1'b0, cl);
        sref <= 16'sd9; settle; chkb("clamp", 1'b1, cl);
        sref <= 16'sd10; settle; chkb("clamp", 1'b0, cl);
        bus(1, OFS_MAX_SPD, 32'h64); bus(1, OFS_CLAMP_SPD, 32'hbb8);
        sref <= 16'sd99; settle; chkb("clamp", 1'b1, cl);
        sref <= 16'sd100; settle; chkb("clamp", 1'b0, cl);
        bus(1, OFS_CTRL, 32'h20); cr_n <= 1'b1; ca_n <= 1'b0;
        sref <= 16'sd5; settle; chkb("alt", 1'b1, cl);
        ca_n <= 1'b1; settle; chkb("alt", 1'b0, cl);
        $display("test clamp done");
    endtask
    task automatic steps(input int n, input bit ph);
        for (int i = 0; i < n; i++) begin
            pos = pos + 1;
            {ea, eb} <= (pos % 4 == 1) ? 2'b10 : (pos % 4 == 2) ? 2'b11 :
                        (pos % 4 == 3) ? 2'b01 : 2'b00;
            settle;
            if (ph) chk("phase", 32'({ea, eb}), 32'({oa, ob}));
            chk("diff", 32'({~oa, ~ob}), 32'({oan, obn}));
        end
    endtask
    task automatic test_enc;
        bus(1, OFS_CTRL, 32'h0);
        k = edges; steps(16, 1); chk("a_edges", 32'(k + 4), 32'(edges));
        bus(1, OFS_CTRL, 32'h10);
        k = edges; steps(8, 1); chk("a_edges", 32'(k + 2), 32'(edges));
        for (int i = 0; i < 2; i++) begin
            ei <= 1'b1; settle; chkb("index", 1'b1, oi); chkb("index_n", 1'b0, oin);
            ei <= 1'b0; settle;
        end
        chkb("trusted", 1'b1, trusted);
        // Half the pulses per revolution, loaded by the restart bit
        bus(1, OFS_PPR, 32'h2000); bus(1, OFS_CTRL, 32'h100);
        k = edges; steps(16, 0); chk("a_edges", 32'(k + 2), 32'(edges));
        $display("test encoder done");
    endtask
    task automatic test_shape;
        bus(1, OFS_SCURVE, 32'h1); bus(1, OFS_CTRL, 32'h40);
        sref <= 16'sd1000; repeat (12) @(posedge mclk);
        chkb("scurve_lag", 1'b1, scmd < 16'sd1000);
        repeat (800) @(posedge mclk);
        chk("scurve_end", 32'(16'sd1000), 32'(scmd));
        $display("test shape done");
    endtask
    initial begin
        rstn = 1'b0; rd = 1'b0; wr = 1'b0; adr = '0; wd = '0; sref = '0; aspd = '0;
        cr_n = 1'b1; ca_n = 1'b1; pdone = 1'b0; ea = 1'b0; eb = 1'b0; ei = 1'b0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        test_regs;
        test_match;
        test_clamp;
        test_enc;
        test_shape;
        final_report;
    end
endmodule
